// *** rtl/bpc_defines.svh ***
// Register indices, reset values and field positions of the battery power register bank.
// Assumes inclusion by bare name from rtl/.
`ifndef BPC_DEFINES_SVH
`define BPC_DEFINES_SVH
`define BPC_IDX_CHG_CONT 8'hd0
`define BPC_IDX_DCH_PRI 8'hd1
`define BPC_IDX_DCH_SEL 8'hd2
`define BPC_IDX_WAR_ABS 8'hd3
`define BPC_IDX_LOW_ABS 8'hd5
`define BPC_IDX_WAR_REL 8'hd7
`define BPC_IDX_LOW_REL 8'hd8
`define BPC_IDX_FULL 8'hd9
`define BPC_IDX_CUR 8'hda
`define BPC_IDX_TRIP 8'hdb
`define BPC_IDX_LED_CTL 8'he0
`define BPC_IDX_ACPI 8'he1
`define BPC_IDX_OFF_TIME 8'he2
`define BPC_IDX_POLL_ADDR 8'he3
`define BPC_IDX_HIGH_ALARM 8'he4
`define BPC_IDX_LOW_ALARM 8'he5
`define BPC_IDX_STATUS 8'hf8
`define BPC_RST_WAR_REL 8'h10
`define BPC_RST_LOW_REL 8'h06
`define BPC_RST_FULL 8'hbe
`define BPC_RST_OFF_TIME 8'h64
`define BPC_REL_MAX 8'hc8
`define BPC_PRI_SAME0 3'h6
`define BPC_PRI_SIMUL 3'h7
`define BPC_LED_KEEP 2
`define BPC_LED_BAY 1
`define BPC_LED_POW 0
`define BPC_CHARGE_READY_N_BIT 4
`define BPC_BLINK_CYCLES 24'd6250000
`define BPC_RESP_OKAY 2'h0
`define BPC_RESP_SLVERR 2'h2
`endif

// *** rtl/bpc_pkg.sv ***
// Types shared by the battery power register bank.
// Assumes bpc_defines.svh is on the include path.
package bpc_pkg;
    typedef struct packed {
        logic [1:0] charging;
        logic charge_ready_n;
        logic [7:0] current_code;
        logic [15:0] capacity1;
        logic [15:0] capacity2;
        logic [7:0] rel_capacity;
        logic [1:0] installed;
        logic poll_strobe;
        logic [7:0] poll_data;
    } bpc_status_t;
    typedef struct packed {
        logic trip;
        logic abs_warn;
        logic abs_low;
        logic rel_warn;
        logic rel_low;
        logic full;
        logic high_alarm;
        logic low_alarm;
    } bpc_event_t;
endpackage

// *** rtl/bpc_regs.sv ***
// Battery power controller register bank behind an AXI4-Lite slave.
// Assumes status inputs are synchronous to mclk_in; byte address = 4 x register index.
// Behaviour
// - Charge control reports ready-low and charging flags
// - Priority code internal only; 6 acts as 0
// - One discharge select bit per battery
// - Absolute warning threshold compared against capacity
// - Absolute low threshold detects low capacity
// - Relative thresholds capped at C8h
// - Full-charge cancel point ends charging
// - Cancel point survives S4/S5 sleep
// - Charging current code read-only to host
// - Trip zero clears; all below flags trip
// - Read-only write readable until refresh
// - Keep bit preserves registers at power-off
// - Bay enable drives per-bay discharge LEDs
// - Power enable blinks LED when installed
// - Mode bit: ACPI one, legacy zero
// - Override timer code zero is reserved
// - Poll address zero disables polling
// - Signed high alarm on greater-or-equal
// - Signed low alarm on less-or-equal
`include "bpc_defines.svh"
module bpc_regs #(
    parameter logic [23:0] BLINK_CYCLES = `BPC_BLINK_CYCLES
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // Power state
    input wire logic sys_power_off_in,
    input wire logic sleep_s4s5_in,
    input wire logic trip_event_en_in,
    // Internal controller side
    input wire bpc_pkg::bpc_status_t status_in,
    input wire logic pri_wr_in,
    input wire logic [2:0] pri_data_in,
    // AXI4-Lite write
    input wire logic [9:0] s_awaddr_in,
    input wire logic s_awvalid_in,
    output logic s_awready_out,
    input wire logic [31:0] s_wdata_in,
    input wire logic [3:0] s_wstrb_in,
    input wire logic s_wvalid_in,
    output logic s_wready_out,
    output logic [1:0] s_bresp_out,
    output logic s_bvalid_out,
    input wire logic s_bready_in,
    // AXI4-Lite read
    input wire logic [9:0] s_araddr_in,
    input wire logic s_arvalid_in,
    output logic s_arready_out,
    output logic [31:0] s_rdata_out,
    output logic [1:0] s_rresp_out,
    output logic s_rvalid_out,
    input wire logic s_rready_in,
    // Block outputs
    output logic [1:0] discharge_sel_out,
    output logic [2:0] discharge_order_out,
    output logic [1:0] bay_indicator_n_out,
    output logic power_indicator_out,
    output logic os_acpi_select_out,
    output logic poll_enable_out,
    output logic [6:0] poll_slave_addr_out,
    output logic [7:0] off_time_out,
    output logic charge_stop_out,
    output bpc_pkg::bpc_event_t events_out
);
    import bpc_pkg::*;

    logic [1:0] charge_ctl;
    logic [2:0] dch_pri;
    logic [1:0] dch_sel;
    logic [15:0] war_abs;
    logic [15:0] low_abs;
    logic [7:0] war_rel;
    logic [7:0] low_rel;
    logic [7:0] full_pt;
    logic [7:0] cur_shadow;
    logic [7:0] cur_last;
    logic [15:0] trip_pt;
    logic [2:0] led_ctl;
    logic os_acpi_select;
    logic [7:0] off_time;
    logic [7:0] poll_addr;
    logic [7:0] high_alarm;
    logic [7:0] low_alarm;
    logic [23:0] blink_cnt;
    logic blink;

    // Write channel: address and data captured independently
    logic aw_held;
    logic w_held;
    logic [7:0] aw_idx;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_take;
    logic w_take;
    logic do_write;
    logic [7:0] wb;
    logic wb0;
    logic wb1;
    assign aw_take = s_awvalid_in && s_awready_out;
    assign w_take = s_wvalid_in && s_wready_out;
    assign do_write = aw_held && w_held && !s_bvalid_out && clk_en_in;
    assign wb = w_data[7:0];
    assign wb0 = w_strb[0];
    assign wb1 = w_strb[1];

    // Clear-on-power-off unless kept by the keep bit
    logic wipe;
    assign wipe = sys_power_off_in && !led_ctl[`BPC_LED_KEEP];

    // Write decode
    logic wr_chg;
    logic wr_sel;
    logic wr_war_abs;
    logic wr_low_abs;
    logic wr_war_rel;
    logic wr_low_rel;
    logic wr_full;
    logic wr_cur;
    logic wr_trip;
    logic wr_led;
    logic wr_acpi;
    logic wr_off;
    logic wr_paddr;
    logic wr_high;
    logic wr_low;
    assign wr_chg = do_write && wb0 && aw_idx == `BPC_IDX_CHG_CONT;
    assign wr_sel = do_write && wb0 && aw_idx == `BPC_IDX_DCH_SEL;
    assign wr_war_abs = do_write && aw_idx == `BPC_IDX_WAR_ABS;
    assign wr_low_abs = do_write && aw_idx == `BPC_IDX_LOW_ABS;
    assign wr_war_rel = do_write && wb0 && aw_idx == `BPC_IDX_WAR_REL && wb <= `BPC_REL_MAX;
    assign wr_low_rel = do_write && wb0 && aw_idx == `BPC_IDX_LOW_REL && wb <= `BPC_REL_MAX;
    assign wr_full = do_write && wb0 && aw_idx == `BPC_IDX_FULL && wb <= `BPC_REL_MAX;
    assign wr_cur = do_write && wb0 && aw_idx == `BPC_IDX_CUR;
    assign wr_trip = do_write && aw_idx == `BPC_IDX_TRIP;
    assign wr_led = do_write && wb0 && aw_idx == `BPC_IDX_LED_CTL;
    assign wr_acpi = do_write && wb0 && aw_idx == `BPC_IDX_ACPI;
    assign wr_off = do_write && wb0 && aw_idx == `BPC_IDX_OFF_TIME && wb != 8'h00;
    assign wr_paddr = do_write && wb0 && aw_idx == `BPC_IDX_POLL_ADDR;
    assign wr_high = do_write && wb0 && aw_idx == `BPC_IDX_HIGH_ALARM;
    assign wr_low = do_write && wb0 && aw_idx == `BPC_IDX_LOW_ALARM;

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_bvalid_out <= 1'b0;
            s_awready_out <= 1'b1;
            s_wready_out <= 1'b1;
        end
        else if (clk_en_in)
        begin
            if (aw_take)
            begin
                aw_held <= 1'b1;
                s_awready_out <= 1'b0;
                aw_idx <= s_awaddr_in[9:2];
            end
            if (w_take)
            begin
                w_held <= 1'b1;
                s_wready_out <= 1'b0;
                w_data <= s_wdata_in;
                w_strb <= s_wstrb_in;
            end
            // Ready flops hold the inverse of the held flags so each output leaves a flip-flop
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_awready_out <= 1'b1;
                s_wready_out <= 1'b1;
                s_bvalid_out <= 1'b1;
            end
            else if (s_bvalid_out && s_bready_in)
                s_bvalid_out <= 1'b0;
        end
    end
    assign s_bresp_out = `BPC_RESP_OKAY;

    // 16-bit registers take both low byte lanes
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            charge_ctl <= 2'h0;
            dch_sel <= 2'h0;
            war_abs <= 16'h0000;
            low_abs <= 16'h0000;
            war_rel <= `BPC_RST_WAR_REL;
            low_rel <= `BPC_RST_LOW_REL;
            trip_pt <= 16'h0000;
            os_acpi_select <= 1'b0;
            off_time <= `BPC_RST_OFF_TIME;
            poll_addr <= 8'h00;
            high_alarm <= 8'h00;
            low_alarm <= 8'h00;
        end
        else if (clk_en_in)
        begin
            if (wipe)
            begin
                charge_ctl <= 2'h0;
                dch_sel <= 2'h0;
                war_abs <= 16'h0000;
                low_abs <= 16'h0000;
                war_rel <= `BPC_RST_WAR_REL;
                low_rel <= `BPC_RST_LOW_REL;
                trip_pt <= 16'h0000;
                os_acpi_select <= 1'b0;
                off_time <= `BPC_RST_OFF_TIME;
                poll_addr <= 8'h00;
                high_alarm <= 8'h00;
                low_alarm <= 8'h00;
            end
            else
            begin
                if (wr_chg)
                    charge_ctl <= wb[1:0];
                if (wr_sel)
                    dch_sel <= wb[1:0];
                if (wr_war_abs)
                    war_abs <= merge16(war_abs, w_data, w_strb);
                if (wr_low_abs)
                    low_abs <= merge16(low_abs, w_data, w_strb);
                if (wr_war_rel)
                    war_rel <= wb;
                if (wr_low_rel)
                    low_rel <= wb;
                if (wr_trip)
                    trip_pt <= merge16(trip_pt, w_data, w_strb);
                if (wr_acpi)
                    os_acpi_select <= wb[0];
                if (wr_off)
                    off_time <= wb;
                if (wr_paddr)
                    poll_addr <= {1'b0, wb[6:0]};
                if (wr_high)
                    high_alarm <= wb;
                if (wr_low)
                    low_alarm <= wb;
            end
        end
    end

    // Cancel point and keep control are never wiped by power state
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            full_pt <= `BPC_RST_FULL;
            led_ctl <= 3'h0;
            dch_pri <= 3'h0;
        end
        else if (clk_en_in)
        begin
            if (wr_full)
                full_pt <= wb;
            if (wr_led)
                led_ctl <= wb[2:0];
            if (pri_wr_in)
                dch_pri <= pri_data_in;
        end
    end

    // Host write shows until the controller refreshes the current code
    logic cur_refresh;
    assign cur_refresh = status_in.current_code != cur_last;
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cur_shadow <= 8'h00;
            cur_last <= 8'h00;
        end
        else if (clk_en_in)
        begin
            cur_last <= status_in.current_code;
            if (cur_refresh)
                cur_shadow <= status_in.current_code;
            else if (wr_cur)
                cur_shadow <= wb;
        end
    end

    // Read channel
    logic [7:0] ar_idx;
    logic [15:0] rd_val;
    logic [7:0] charge_rd;
    logic [7:0] status_rd;
    assign ar_idx = s_araddr_in[9:2];
    assign charge_rd = {3'h0, status_in.charge_ready_n, 2'h0, status_in.charging};
    assign status_rd = {events_out.trip, events_out.abs_warn, events_out.abs_low, events_out.rel_warn,
        events_out.rel_low, events_out.full, events_out.high_alarm, events_out.low_alarm};
    always_comb
    begin
        unique case (ar_idx)
            `BPC_IDX_CHG_CONT: rd_val = {8'h00, charge_rd};
            `BPC_IDX_DCH_PRI: rd_val = {13'h0000, dch_pri};
            `BPC_IDX_DCH_SEL: rd_val = {14'h0000, dch_sel};
            `BPC_IDX_WAR_ABS: rd_val = war_abs;
            `BPC_IDX_LOW_ABS: rd_val = low_abs;
            `BPC_IDX_WAR_REL: rd_val = {8'h00, war_rel};
            `BPC_IDX_LOW_REL: rd_val = {8'h00, low_rel};
            `BPC_IDX_FULL: rd_val = {8'h00, full_pt};
            `BPC_IDX_CUR: rd_val = {8'h00, cur_shadow};
            `BPC_IDX_TRIP: rd_val = trip_pt;
            `BPC_IDX_LED_CTL: rd_val = {13'h0000, led_ctl};
            `BPC_IDX_ACPI: rd_val = {15'h0000, os_acpi_select};
            `BPC_IDX_OFF_TIME: rd_val = {8'h00, off_time};
            `BPC_IDX_POLL_ADDR: rd_val = {8'h00, poll_addr};
            `BPC_IDX_HIGH_ALARM: rd_val = {8'h00, high_alarm};
            `BPC_IDX_LOW_ALARM: rd_val = {8'h00, low_alarm};
            `BPC_IDX_STATUS: rd_val = {8'h00, status_rd};
            default: rd_val = 16'h0000;
        endcase
    end
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s_rvalid_out <= 1'b0;
            s_rdata_out <= 32'h0000_0000;
            s_arready_out <= 1'b1;
        end
        else if (clk_en_in)
        begin
            if (s_arvalid_in && s_arready_out)
            begin
                s_rvalid_out <= 1'b1;
                s_arready_out <= 1'b0;
                s_rdata_out <= {16'h0000, rd_val};
            end
            else if (s_rvalid_out && s_rready_in)
            begin
                s_rvalid_out <= 1'b0;
                s_arready_out <= 1'b1;
            end
        end
    end
    assign s_rresp_out = `BPC_RESP_OKAY;

    // Threshold comparisons
    bpc_event_t next_events;
    logic trip_armed;
    assign trip_armed = trip_pt != 16'h0000 && trip_event_en_in;
    always_comb
    begin
        next_events.trip = trip_armed && status_in.capacity1 < trip_pt && status_in.capacity2 < trip_pt;
        next_events.abs_warn = status_in.capacity1 <= war_abs;
        next_events.abs_low = status_in.capacity1 <= low_abs;
        next_events.rel_warn = status_in.rel_capacity <= war_rel;
        next_events.rel_low = status_in.rel_capacity <= low_rel;
        next_events.full = status_in.rel_capacity >= full_pt;
        next_events.high_alarm = poll_enable_out && status_in.poll_strobe
            && $signed(status_in.poll_data) >= $signed(high_alarm);
        next_events.low_alarm = poll_enable_out && status_in.poll_strobe
            && $signed(status_in.poll_data) <= $signed(low_alarm);
    end

    // Blink timer for the power LED
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            blink_cnt <= 24'h000000;
            blink <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (blink_cnt >= BLINK_CYCLES - 24'h000001)
            begin
                blink_cnt <= 24'h000000;
                blink <= !blink;
            end
            else
                blink_cnt <= blink_cnt + 24'h000001;
        end
    end

    // Registered block outputs
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            discharge_sel_out <= 2'h0;
            discharge_order_out <= 3'h0;
            bay_indicator_n_out <= 2'h3;
            power_indicator_out <= 1'b0;
            os_acpi_select_out <= 1'b0;
            poll_enable_out <= 1'b0;
            poll_slave_addr_out <= 7'h00;
            off_time_out <= `BPC_RST_OFF_TIME;
            charge_stop_out <= 1'b0;
            events_out <= '0;
        end
        else if (clk_en_in)
        begin
            discharge_sel_out <= dch_sel;
            discharge_order_out <= (dch_pri == `BPC_PRI_SAME0) ? 3'h0 : dch_pri;
            bay_indicator_n_out <= led_ctl[`BPC_LED_BAY] ? ~dch_sel : 2'h3;
            power_indicator_out <= led_ctl[`BPC_LED_POW] && (|status_in.installed) && blink;
            os_acpi_select_out <= os_acpi_select;
            poll_enable_out <= poll_addr[6:0] != 7'h00;
            poll_slave_addr_out <= poll_addr[6:0];
            off_time_out <= off_time;
            charge_stop_out <= next_events.full;
            events_out <= next_events;
        end
    end

    a_poll_disable: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        clk_en_in && poll_addr == 8'h00 |=> !poll_enable_out)
        else $error("poll enabled with zero address");
    a_rel_cap: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        war_rel <= `BPC_REL_MAX && low_rel <= `BPC_REL_MAX)
        else $error("relative threshold above max");
    a_off_nonzero: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        off_time != 8'h00)
        else $error("override timer zero");
    a_trip_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        clk_en_in && trip_pt == 16'h0000 |=> !events_out.trip)
        else $error("trip flagged with cleared point");
    a_bay_off: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        clk_en_in && !led_ctl[`BPC_LED_BAY] |=> bay_indicator_n_out == 2'h3)
        else $error("bay leds lit while disabled");
    a_full_kept: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !wr_full |=> $stable(full_pt))
        else $error("cancel point changed without write");
    a_pri_map: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        clk_en_in && dch_pri == `BPC_PRI_SAME0 |=> discharge_order_out == 3'h0)
        else $error("priority six not mapped to zero");
    a_keep_regs: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        clk_en_in && sys_power_off_in && led_ctl[`BPC_LED_KEEP] && !do_write |=> $stable(war_abs))
        else $error("register wiped while keep set");
    a_blink_off: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        clk_en_in && status_in.installed == 2'h0 |=> !power_indicator_out)
        else $error("power led on with no battery");
    a_cur_refresh: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        clk_en_in && cur_refresh |=> cur_shadow == $past(status_in.current_code))
        else $error("current code not refreshed");
endmodule

// *** sim/bpc_status_model.sv ***
// Stand-in for the controller side that feeds battery status into the bank.
// Assumes the bench sets levels at clock edges; poll results leave as one-cycle strobes.
module bpc_status_model (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Bench controls
    input wire logic [7:0] cur_in,
    input wire logic [15:0] cap_in,
    input wire logic [7:0] rel_in,
    input wire logic poll_in,
    input wire logic [7:0] poll_val_in,
    // Status toward the bank
    output bpc_pkg::bpc_status_t status_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import bpc_pkg::*;
    logic strobe;
    logic [7:0] pdata;
    // Poll data is only meaningful with its strobe, so it is scrambled otherwise
    always_ff @(posedge mclk_in or negedge rst_n_in)
        if (!rst_n_in)
        begin
            strobe <= 1'b0;
            pdata <= 8'h00;
        end
        else
        begin
            strobe <= poll_in;
            pdata <= poll_in ? poll_val_in : ~pdata;
        end
    assign status_out = {2'b01, 1'b0, cur_in, cap_in, cap_in, rel_in, 2'b01, strobe, pdata};
endmodule

// *** sim/bpc_regs_test.sv ***
// Self-checking bench of the battery power register bank over AXI4-Lite.
// Assumes bpc_status_model on the status side and a shortened blink period.
module bpc_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import bpc_pkg::*;
    logic mclk_in, rst_n_in, pwr_off, sleep, trip_en, pri_wr, poll;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [2:0] pri_d, order;
    logic [9:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed;
    logic [3:0] wstrb;
    logic [7:0] cur, rel, pval, offt;
    logic [15:0] cap;
    logic [1:0] bresp, rresp, dsel, bay_n;
    logic pwr_led, acpi, poll_en, stop;
    logic [6:0] paddr;
    bpc_status_t st;
    bpc_event_t ev;
    logic [31:0] exp_q[$];
    logic [7:0] ri[16] = '{8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd5, 8'hd7, 8'hd8, 8'hd9,
                           8'hda, 8'hdb, 8'he0, 8'he1, 8'he2, 8'he3, 8'he4, 8'hdd};
    logic [7:0] re[16] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h06, 8'hbe,
                           8'h00, 8'h00, 8'h00, 8'h00, 8'h64, 8'h00, 8'h00, 8'h00};
    int n_fail, total_checks;

    bpc_status_model i_bpc_status_model (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .cur_in(cur),
        .cap_in(cap), .rel_in(rel), .poll_in(poll), .poll_val_in(pval), .status_out(st));
    bpc_regs #(.BLINK_CYCLES(24'h000004)) i_bpc_regs (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .clk_en_in(1'b1), .sys_power_off_in(pwr_off), .sleep_s4s5_in(sleep), .trip_event_en_in(trip_en),
        .status_in(st), .pri_wr_in(pri_wr), .pri_data_in(pri_d), .s_awaddr_in(awaddr),
        .s_awvalid_in(awvalid), .s_awready_out(awready), .s_wdata_in(wdata), .s_wstrb_in(wstrb),
        .s_wvalid_in(wvalid), .s_wready_out(wready), .s_bresp_out(bresp), .s_bvalid_out(bvalid),
        .s_bready_in(bready), .s_araddr_in(araddr), .s_arvalid_in(arvalid), .s_arready_out(arready),
        .s_rdata_out(rdata), .s_rresp_out(rresp), .s_rvalid_out(rvalid), .s_rready_in(rready),
        .discharge_sel_out(dsel), .discharge_order_out(order), .bay_indicator_n_out(bay_n),
        .power_indicator_out(pwr_led), .os_acpi_select_out(acpi), .poll_enable_out(poll_en),
        .poll_slave_addr_out(paddr), .off_time_out(offt), .charge_stop_out(stop), .events_out(ev));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic tally(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        tally(got, exp);
    endtask

    task automatic cmp_out(input logic [31:0] got, input logic [31:0] exp);
        tally(got, exp);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic bound(input int n);
        if (n >= 100)
        begin
            n_fail++;
            results();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_in);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge mclk_in);
            n++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid && n < 100);
        bready <= 1'b0;
        cmp_out(bresp, 2'h0);
        bound(n);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        int n;
        n = 0;
        exp_q.push_back(e);
        @(posedge mclk_in);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge mclk_in);
            n++;
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid && n < 100);
        rready <= 1'b0;
        bound(n);
    endtask

    task automatic wrd(input logic [7:0] idx, input logic [31:0] d, input logic [31:0] e);
        wr(idx, d);
        rd(idx, e);
    endtask

    task automatic settle;
        repeat (2) @(posedge mclk_in);
        #1;
    endtask

    task automatic alarm(input logic [7:0] v, input logic [31:0] hi, input logic [31:0] lo);
        int h, l;
        h = 0;
        l = 0;
        @(posedge mclk_in);
        pval <= v;
        poll <= 1'b1;
        @(posedge mclk_in);
        poll <= 1'b0;
        repeat (6)
        begin
            @(posedge mclk_in);
            #1;
            h += (ev.high_alarm === 1'b1);
            l += (ev.low_alarm === 1'b1);
        end
        cmp_out(h, hi);
        cmp_out(l, lo);
    endtask

    task automatic power_cycle;
        @(posedge mclk_in);
        pwr_off <= 1'b1;
        sleep <= 1'b1;
        repeat (3) @(posedge mclk_in);
        pwr_off <= 1'b0;
        sleep <= 1'b0;
    endtask

    always @(posedge mclk_in)
        if (rvalid && rready && exp_q.size() > 0)
        begin
            cmp_rd(rdata, exp_q.pop_front());
            cmp_out(rresp, 2'h0);
        end

    initial
    begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end

    initial
    begin
        int k;
        {rst_n_in, pwr_off, sleep, trip_en, pri_wr, poll, awvalid, wvalid, bready, arvalid, rready} = '0;
        {pri_d, awaddr, araddr, wdata, cur, cap, pval} = '0;
        wstrb = 4'hf;
        rel = 8'hc0;
        seed = 32'h2fa876c2;
        n_fail = 0;
        total_checks = 0;
        repeat (2) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        for (k = 0; k < 16; k++)
            rd(ri[k], {24'h0, re[k]});
        $display("test reset values done");
        wrd(8'hd7, 32'hc9, 32'h10);
        wrd(8'hd7, 32'hc8, 32'hc8);
        wrd(8'hd8, 32'hc9, 32'h06);
        wrd(8'he2, 32'h00, 32'h64);
        wrd(8'he2, 32'hff, 32'hff);
        wrd(8'hd1, 32'h05, 32'h00);
        wrd(8'hdd, 32'h5a, 32'h00);
        wrd(8'hda, 32'h33, 32'h33);
        @(posedge mclk_in);
        cur <= 8'h07;
        rd(8'hda, 32'h07);
        $display("test write and refusal done");
        wrd(8'he3, 32'hff, 32'h7f);
        wrd(8'he1, 32'h01, 32'h01);
        wrd(8'hd2, 32'h01, 32'h01);
        settle();
        cmp_out({poll_en, paddr, acpi, dsel, bay_n, offt}, {8'hff, 1'b1, 2'b01, 2'b11, 8'hff});
        wr(8'he0, 32'h03);
        settle();
        cmp_out(bay_n, 2'b10);
        k = 0;
        repeat (20)
        begin
            @(posedge mclk_in);
            #1;
            k += (pwr_led === 1'b1);
        end
        cmp_out(k > 3 && k < 17, 1);
        wrd(8'he3, 32'h00, 32'h00);
        settle();
        cmp_out(poll_en, 1'b0);
        $display("test outputs done");
        repeat (4)
        begin
            seed = lfsr(seed);
            wrd(8'hd3, {16'h0, seed[15:0]}, {16'h0, seed[15:0]});
            wrd(8'hd5, {16'h0, seed[31:16]}, {16'h0, seed[31:16]});
        end
        wr(8'hd3, 32'h100);
        wr(8'hd5, 32'h80);
        wr(8'hdb, 32'h100);
        @(posedge mclk_in);
        cap <= 16'h80;
        trip_en <= 1'b1;
        settle();
        cmp_out({ev.trip, ev.abs_warn, ev.abs_low, ev.rel_warn, ev.rel_low, ev.full}, 6'b111101);
        @(posedge mclk_in);
        cap <= 16'h100;
        settle();
        cmp_out({ev.trip, ev.abs_warn, ev.abs_low, ev.rel_warn, ev.rel_low, ev.full}, 6'b010101);
        rd(8'hf8, 32'h54);
        wr(8'hdb, 32'h0);
        @(posedge mclk_in);
        cap <= 16'h0;
        settle();
        cmp_out(ev.trip, 1'b0);
        cmp_out(stop, 1'b1);
        wr(8'hd9, 32'hc8);
        settle();
        cmp_out(stop, 1'b0);
        $display("test events done");
        wr(8'he3, 32'h48);
        wr(8'he4, 32'h05);
        alarm(8'h05, 1, 0);
        alarm(8'h04, 0, 0);
        alarm(8'h80, 0, 1);
        @(posedge mclk_in);
        pri_d <= 3'h6;
        pri_wr <= 1'b1;
        @(posedge mclk_in);
        pri_wr <= 1'b0;
        settle();
        cmp_out(order, 3'h0);
        @(posedge mclk_in);
        pri_d <= 3'h7;
        pri_wr <= 1'b1;
        @(posedge mclk_in);
        pri_wr <= 1'b0;
        settle();
        cmp_out(order, 3'h7);
        $display("test alarms and priority done");
        wr(8'he0, 32'h00);
        power_cycle();
        rd(8'hd7, 32'h10);
        rd(8'hd9, 32'hc8);
        wr(8'he0, 32'h04);
        wr(8'hd7, 32'h20);
        power_cycle();
        rd(8'hd7, 32'h20);
        rd(8'he0, 32'h04);
        $display("test power off done");
        @(posedge mclk_in);
        results();
    end
endmodule
